// *** design/mmr_pkg.sv ***
package mmr_pkg;

   // ****************************************************************
   // Register offsets (byte addresses on the register port)
   // ****************************************************************
   localparam logic [9:0] OFS_SPARE_LINK_RX_BUFFER = 10'h1dc;
   localparam logic [9:0] OFS_CODE_VIOLATION_COUNTER = 10'h1e0;
   localparam logic [9:0] OFS_FRAMING_BIT_ERROR_COUNTER = 10'h1e4;
   localparam logic [9:0] OFS_P_BIT_PARITY_COUNTER = 10'h1e8;
   localparam logic [9:0] OFS_PATH_PARITY_COUNTER = 10'h1ec;
   localparam logic [9:0] OFS_FAR_END_BLOCK_COUNTER = 10'h1f0;
   localparam logic [9:0] OFS_ZERO_STRING_COUNTER = 10'h1f4;
   localparam logic [9:0] OFS_ALARM_PARAMETERS = 10'h1f8;
   localparam logic [9:0] OFS_DS2_TX_GROUP_SELECT = 10'h200;
   localparam logic [9:0] OFS_DS2_TX_CONFIG = 10'h204;
   localparam logic [9:0] OFS_DS2_TX_COMMAND = 10'h208;
   localparam logic [9:0] OFS_DS2_TX_LOOPBACK_INSERT = 10'h20c;
   localparam logic [9:0] OFS_DS2_RX_GROUP_SELECT = 10'h220;

   // ****************************************************************
   // Reset values and field layout
   // ****************************************************************
   localparam logic [15:0] RST_SPARE_LINK_RX_BUFFER = 16'h01ff;
   localparam logic [15:0] RST_ZERO = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam int SPARE_BITS = 9;
   localparam int NUM_COUNTERS = 6;
   localparam int NUM_GROUPS = 7;
   localparam int AP_AIS_BIT = 7;
   localparam int AP_THR_MSB = 5;
   localparam logic [3:0] AIS_ERR_LIMIT_LOW = 4'h8;
   localparam logic [3:0] AIS_ERR_LIMIT_HIGH = 4'hf;
   localparam logic [2:0] GROUP_MAX = 3'h6;

   // Counter indices.
   localparam int CI_CV = 0;
   localparam int CI_FB = 1;
   localparam int CI_PB = 2;
   localparam int CI_CP = 3;
   localparam int CI_FE = 4;
   localparam int CI_ZS = 5;

   // Spare link timing: multiframe period in ns, and cycles at 200 MHz.
   localparam int MULTIFRAME_NS = 106000;
   localparam int CLK_PERIOD_NS = 5;
   localparam int MULTIFRAME_CYCLES = MULTIFRAME_NS / CLK_PERIOD_NS;

   // Counter mode encoding.
   typedef enum logic {
      MMR_CLEAR_ON_READ = 1'b0,
      MMR_ERRORED_SECOND = 1'b1
   } mmr_cnt_mode_t;

endpackage

// *** design/mmr_monitor_regs.sv ***
`timescale 1ns/1ps
// How it works
// RQ1 - Latch nine spare link bits into buffer.
// RQ2 - Optional interrupt once every multiframe.
// RQ3 - Software reads buffer within one multiframe.
// RQ4 - Counters clear-on-read or errored-second mode.
// RQ5 - Count code violations unless asynchronous.
// RQ6 - Count framing errors unless out of frame.
// RQ7 - One P-bit error per multiframe maximum.
// RQ8 - One CP error per multiframe maximum.
// RQ9 - One far-end block error per multiframe.
// RQ10 - Count zero strings unless asynchronous.
// RQ11 - AIS error limit eight or fifteen.
// RQ12 - Six-bit frame persistence threshold.
// RQ13 - Transmit group index selects DS2 group.
// RQ14 - Receive group index selects DS2 group.
// RQ15 - Software sets group before group access.
// RQ16 - Loopback selects which C-bit inverts.
// RQ17 - Mode bit picks DS1 or E1 mux.
// RQ18 - Fault code selects transmit error pattern.
// RQ19 - Remote alarm bit position by mode.
// RQ20 - Reserved bit sent as programmed.
// RQ21 - Per-tributary loopback code enables.
// RQ22 - Flag full spare link buffer.
// RQ23 - Counters saturate at maximum.
module mmr_monitor_regs (
   // Clock and reset.
   input wire logic clk,
   input wire logic arst_n,
   // Register port.
   input wire logic regSel,
   input wire logic regWr,
   input wire logic [9:0] regAddr,
   input wire logic [15:0] regWdata,
   output logic [15:0] regRdata,
   output logic regAck,
   // DS3 receive framer status levels, spare bits and events; the events are one-cycle pulses on clk.
   input wire logic ds3Async,
   input wire logic ds3OutOfFrame,
   input wire logic multiframeEnd,
   input wire logic [mmr_pkg::SPARE_BITS-1:0] spare_link_bits,
   input wire logic codeViolationEvt,
   input wire logic framingErrEvt,
   input wire logic pBitErrEvt,
   input wire logic pathParityErrEvt,
   input wire logic farEndBlockErrEvt,
   input wire logic zeroStringEvt,
   input wire logic oneSecondTick,
   // Spare link control and status.
   input wire logic spareIrqEnable,
   input wire logic counter_mode_select,
   output logic spare_buffer_full_flag,
   output logic spareIrq,
   // Alarm settings to the DS3 alarm integrators.
   input wire logic [3:0] aisErrCount,
   output logic aisMultiframeValid,
   output logic [5:0] alarm_frame_threshold,
   // DS2 group settings to the per-group transmitters.
   output logic [2:0] txGroupIndex,
   output logic [2:0] rxGroupIndex,
   output logic [mmr_pkg::NUM_GROUPS-1:0][1:0] loopbackCbitSel,
   output logic [mmr_pkg::NUM_GROUPS-1:0] e1Mode,
   output logic [mmr_pkg::NUM_GROUPS-1:0][1:0] fault_inject_code,
   output logic [mmr_pkg::NUM_GROUPS-1:0] remote_alarm_send,
   output logic [mmr_pkg::NUM_GROUPS-1:0] spare_bit_value,
   output logic [mmr_pkg::NUM_GROUPS-1:0][3:0] loopback_code
);
   import mmr_pkg::*;

   // ****************************************************************
   // Register port decode
   // ****************************************************************
   logic wrStb;
   logic rdStb;
   logic [15:0] nxt_rdata;
   logic [15:0] rdata_ff;
   logic ack_ff;
   logic [NUM_COUNTERS-1:0] cntRead;
   logic [NUM_COUNTERS-1:0] evt;
   logic [15:0] fg_ff [NUM_COUNTERS];
   logic [15:0] bg_ff [NUM_COUNTERS];
   logic [SPARE_BITS-1:0] spare_ff;
   logic full_ff;
   logic irq_ff;
   logic ais_ff;
   logic [5:0] thr_ff;
   logic [2:0] txSel_ff;
   logic [2:0] rxSel_ff;
   // Per-group transmit settings, indexed by the group number.
   logic [1:0] lpSel_ff [NUM_GROUPS];
   logic e1_ff [NUM_GROUPS];
   logic [1:0] fault_ff [NUM_GROUPS];
   logic sra_ff [NUM_GROUPS];
   logic res_ff [NUM_GROUPS];
   logic [3:0] lpc_ff [NUM_GROUPS];
   logic pSeen_ff;
   logic cpSeen_ff;
   logic feSeen_ff;
   logic errSec_ff;

   // One request cycle is one access; a held select repeats the access.
   assign wrStb = regSel && regWr;
   assign rdStb = regSel && !regWr;

   // ****************************************************************
   // Counter events and per-multiframe gating
   // ****************************************************************
   // Folds repeated parity and far-end events into one per multiframe.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pSeen_ff <= 1'b0;
         cpSeen_ff <= 1'b0;
         feSeen_ff <= 1'b0;
      end else if (multiframeEnd) begin
         pSeen_ff <= 1'b0;
         cpSeen_ff <= 1'b0;
         feSeen_ff <= 1'b0;
      end else begin
         pSeen_ff <= pSeen_ff || (pBitErrEvt && !ds3OutOfFrame);
         cpSeen_ff <= cpSeen_ff || (pathParityErrEvt && !ds3OutOfFrame);
         feSeen_ff <= feSeen_ff || (farEndBlockErrEvt && !ds3OutOfFrame);
      end
   end

   always_comb begin
      // RQ5 code violation gating
      evt[CI_CV] = codeViolationEvt && !ds3Async;
      // RQ6 framing error gating
      evt[CI_FB] = framingErrEvt && !ds3OutOfFrame;
      // RQ7 single P-bit count
      evt[CI_PB] = pBitErrEvt && !ds3OutOfFrame && !pSeen_ff && !multiframeEnd;
      // RQ8 single CP count
      evt[CI_CP] = pathParityErrEvt && !ds3OutOfFrame && !cpSeen_ff && !multiframeEnd;
      // RQ9 single far-end count
      evt[CI_FE] = farEndBlockErrEvt && !ds3OutOfFrame && !feSeen_ff && !multiframeEnd;
      // RQ10 zero string gating
      evt[CI_ZS] = zeroStringEvt && !ds3Async;
   end

   // Errored-second mode: each second, background moves to foreground.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         errSec_ff <= 1'b0;
      end else begin
         errSec_ff <= counter_mode_select;
      end
   end

   // ****************************************************************
   // Error counters
   // ****************************************************************
   // Each counter sits four bytes above the one before it.
   // RQ4 counter mode handling
   always_comb begin
      for (int i = 0; i < NUM_COUNTERS; i++) begin
         cntRead[i] = rdStb && (regAddr == OFS_CODE_VIOLATION_COUNTER + 10'(4 * i));
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < NUM_COUNTERS; i++) begin
            bg_ff[i] <= RST_ZERO;
            fg_ff[i] <= RST_ZERO;
         end
      end else begin
         for (int i = 0; i < NUM_COUNTERS; i++) begin
            // Errored-second reads leave the count alone, so it holds for a whole second.
            if (mmr_cnt_mode_t'(errSec_ff) == MMR_ERRORED_SECOND) begin
               if (oneSecondTick) begin
                  fg_ff[i] <= bg_ff[i];
                  bg_ff[i] <= evt[i] ? 16'h0001 : RST_ZERO;
               // RQ23 saturate at maximum
               end else if (evt[i] && bg_ff[i] != CNT_MAX) begin
                  bg_ff[i] <= bg_ff[i] + 16'h0001;
               end
            end else begin
               // A read clears, but an event in the same cycle survives.
               if (cntRead[i]) begin
                  fg_ff[i] <= evt[i] ? 16'h0001 : RST_ZERO;
               // RQ23 saturate at maximum
               end else if (evt[i] && fg_ff[i] != CNT_MAX) begin
                  fg_ff[i] <= fg_ff[i] + 16'h0001;
               end
               bg_ff[i] <= RST_ZERO;
            end
         end
      end
   end

   // ****************************************************************
   // Spare data link buffer
   // ****************************************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         spare_ff <= RST_SPARE_LINK_RX_BUFFER[SPARE_BITS-1:0];
         full_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         if (multiframeEnd) begin
            // RQ1 latch spare bits
            spare_ff <= spare_link_bits;
         end
         // RQ22 buffer full flag, set wins over read
         if (multiframeEnd) begin
            full_ff <= 1'b1;
         end else if (rdStb && regAddr == OFS_SPARE_LINK_RX_BUFFER) begin
            full_ff <= 1'b0;
         end
         // RQ2 multiframe interrupt pulse
         irq_ff <= multiframeEnd && spareIrqEnable;
      end
   end

   // ****************************************************************
   // Alarm parameters and group selects
   // ****************************************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ais_ff <= 1'b0;
         thr_ff <= 6'h00;
         txSel_ff <= 3'h0;
         rxSel_ff <= 3'h0;
      end else if (wrStb) begin
         if (regAddr == OFS_ALARM_PARAMETERS) begin
            ais_ff <= regWdata[AP_AIS_BIT];
            // RQ12 frame persistence threshold
            thr_ff <= regWdata[AP_THR_MSB:0];
         end
         // Group numbers above six are dropped, so a select always names a real group.
         // RQ13 transmit group select
         if (regAddr == OFS_DS2_TX_GROUP_SELECT && regWdata[2:0] <= GROUP_MAX) begin
            txSel_ff <= regWdata[2:0];
         end
         // RQ14 receive group select
         if (regAddr == OFS_DS2_RX_GROUP_SELECT && regWdata[2:0] <= GROUP_MAX) begin
            rxSel_ff <= regWdata[2:0];
         end
      end
   end

   // Combinational, so the integrator sees the verdict in the cycle of its count.
   // RQ11 AIS error limit
   assign aisMultiframeValid = ais_ff ? (aisErrCount < AIS_ERR_LIMIT_HIGH)
                                      : (aisErrCount < AIS_ERR_LIMIT_LOW);

   // ****************************************************************
   // Per-group DS2 transmit registers
   // ****************************************************************
   // RQ15 indirect group write
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int g = 0; g < NUM_GROUPS; g++) begin
            lpSel_ff[g] <= 2'h0;
            e1_ff[g] <= 1'b0;
            fault_ff[g] <= 2'h0;
            sra_ff[g] <= 1'b0;
            res_ff[g] <= 1'b0;
            lpc_ff[g] <= 4'h0;
         end
      end else if (wrStb) begin
         for (int g = 0; g < NUM_GROUPS; g++) begin
            if (txSel_ff == 3'(g)) begin
               if (regAddr == OFS_DS2_TX_CONFIG) begin
                  // RQ16 loopback C-bit select
                  lpSel_ff[g] <= regWdata[2:1];
                  // RQ17 DS1 or E1 mux
                  e1_ff[g] <= regWdata[0];
               end
               if (regAddr == OFS_DS2_TX_COMMAND) begin
                  // RQ18 fault insertion code
                  fault_ff[g] <= regWdata[3:2];
                  // RQ19 remote alarm enable
                  sra_ff[g] <= regWdata[1];
                  // RQ20 reserved bit value
                  res_ff[g] <= regWdata[0];
               end
               if (regAddr == OFS_DS2_TX_LOOPBACK_INSERT) begin
                  // RQ21 tributary loopback enables
                  lpc_ff[g] <= regWdata[3:0];
               end
            end
         end
      end
   end

   // Flattens the per-group settings onto the output ports.
   always_comb begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
         loopbackCbitSel[g] = lpSel_ff[g];
         e1Mode[g] = e1_ff[g];
         fault_inject_code[g] = fault_ff[g];
         remote_alarm_send[g] = sra_ff[g];
         spare_bit_value[g] = res_ff[g];
         loopback_code[g] = lpc_ff[g];
      end
   end

   // ****************************************************************
   // Read data
   // ****************************************************************
   always_comb begin
      nxt_rdata = RST_ZERO;
      unique case (regAddr)
         OFS_SPARE_LINK_RX_BUFFER: nxt_rdata = {7'h00, spare_ff};
         OFS_CODE_VIOLATION_COUNTER: nxt_rdata = fg_ff[CI_CV];
         OFS_FRAMING_BIT_ERROR_COUNTER: nxt_rdata = fg_ff[CI_FB];
         OFS_P_BIT_PARITY_COUNTER: nxt_rdata = fg_ff[CI_PB];
         OFS_PATH_PARITY_COUNTER: nxt_rdata = fg_ff[CI_CP];
         OFS_FAR_END_BLOCK_COUNTER: nxt_rdata = fg_ff[CI_FE];
         OFS_ZERO_STRING_COUNTER: nxt_rdata = fg_ff[CI_ZS];
         OFS_ALARM_PARAMETERS: nxt_rdata = {8'h00, ais_ff, 1'b0, thr_ff};
         OFS_DS2_TX_GROUP_SELECT: nxt_rdata = {13'h0000, txSel_ff};
         OFS_DS2_TX_CONFIG: nxt_rdata = {13'h0000, lpSel_ff[txSel_ff], e1_ff[txSel_ff]};
         OFS_DS2_TX_COMMAND: nxt_rdata = {12'h000, fault_ff[txSel_ff], sra_ff[txSel_ff],
                                          res_ff[txSel_ff]};
         OFS_DS2_TX_LOOPBACK_INSERT: nxt_rdata = {12'h000, lpc_ff[txSel_ff]};
         OFS_DS2_RX_GROUP_SELECT: nxt_rdata = {13'h0000, rxSel_ff};
         default: nxt_rdata = RST_ZERO;
      endcase
   end

   // Read data is zero outside a read answer, so several blocks may share one bus by OR.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_ff <= RST_ZERO;
         ack_ff <= 1'b0;
      end else begin
         rdata_ff <= rdStb ? nxt_rdata : RST_ZERO;
         // Every access, write or read, is answered exactly one cycle later.
         ack_ff <= regSel;
      end
   end

   assign regRdata = rdata_ff;
   assign regAck = ack_ff;
   assign spare_buffer_full_flag = full_ff;
   assign spareIrq = irq_ff;
   assign alarm_frame_threshold = thr_ff;
   assign txGroupIndex = txSel_ff;
   assign rxGroupIndex = rxSel_ff;

endmodule

// *** dv/mmr_monitor_regs_props.sv ***
`timescale 1ns/1ps
module mmr_monitor_regs_props (
   // Clock and reset.
   input wire logic clk,
   input wire logic arst_n,
   // Register port.
   input wire logic regSel,
   input wire logic regWr,
   input wire logic [9:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic [15:0] regRdata,
   input wire logic regAck,
   // Framer events, status and settings.
   input wire logic multiframeEnd,
   input wire logic spareIrqEnable,
   input wire logic spareIrq,
   input wire logic spare_buffer_full_flag,
   input wire logic [3:0] aisErrCount,
   input wire logic aisMultiframeValid,
   input wire logic [5:0] alarm_frame_threshold,
   input wire logic [2:0] txGroupIndex,
   input wire logic [2:0] rxGroupIndex,
   input wire logic [mmr_pkg::NUM_GROUPS-1:0][1:0] loopbackCbitSel,
   input wire logic [mmr_pkg::NUM_GROUPS-1:0] e1Mode,
   input wire logic [mmr_pkg::NUM_GROUPS-1:0][1:0] fault_inject_code,
   input wire logic [mmr_pkg::NUM_GROUPS-1:0] remote_alarm_send,
   input wire logic [mmr_pkg::NUM_GROUPS-1:0] spare_bit_value,
   input wire logic [mmr_pkg::NUM_GROUPS-1:0][3:0] loopback_code
);
   import mmr_pkg::*;
   logic aisHigh_ff;
   logic [3:0] aisLimit;
   logic [2:0] expTx;
   logic [2:0] expRx;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   sequence wrAt(logic [9:0] a);
      regSel && regWr && regAddr == a;
   endsequence
   sequence rdAt(logic [9:0] a);
      regSel && !regWr && regAddr == a;
   endsequence
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         aisHigh_ff <= 1'b0;
      end else if (regSel && regWr && regAddr == OFS_ALARM_PARAMETERS) begin
         aisHigh_ff <= regWdata[AP_AIS_BIT];
      end
   end
   assign aisLimit = aisHigh_ff ? AIS_ERR_LIMIT_HIGH : AIS_ERR_LIMIT_LOW;
   assign expTx = (regWdata[2:0] > GROUP_MAX) ? txGroupIndex : regWdata[2:0];
   assign expRx = (regWdata[2:0] > GROUP_MAX) ? rxGroupIndex : regWdata[2:0];
   irq_per_frame_a: assert property (spareIrq == $past(multiframeEnd && spareIrqEnable))
      else $error("spare interrupt mismatch");
   full_flag_set_a: assert property (multiframeEnd |=> spare_buffer_full_flag)
      else $error("full flag not set");
   full_flag_clr_a: assert property (rdAt(OFS_SPARE_LINK_RX_BUFFER) ##0 !multiframeEnd
      |=> !spare_buffer_full_flag) else $error("full flag not cleared");
   buffer_high_a: assert property (rdAt(OFS_SPARE_LINK_RX_BUFFER)
      |=> regAck && regRdata[15:9] == 7'h00) else $error("buffer upper bits set");
   ais_limit_a: assert property (aisMultiframeValid == (aisErrCount < aisLimit))
      else $error("ais validity wrong");
   thr_write_a: assert property (wrAt(OFS_ALARM_PARAMETERS)
      |=> alarm_frame_threshold == $past(regWdata[5:0])) else $error("threshold wrong");
   tx_group_a: assert property (wrAt(OFS_DS2_TX_GROUP_SELECT) |=> txGroupIndex == $past(expTx))
      else $error("tx group wrong");
   rx_group_a: assert property (wrAt(OFS_DS2_RX_GROUP_SELECT) |=> rxGroupIndex == $past(expRx))
      else $error("rx group wrong");
   tx_config_a: assert property (wrAt(OFS_DS2_TX_CONFIG) |=>
      {loopbackCbitSel[$past(txGroupIndex)], e1Mode[$past(txGroupIndex)]} == $past(regWdata[2:0]))
      else $error("tx config wrong");
   tx_command_a: assert property (wrAt(OFS_DS2_TX_COMMAND) |=>
      {fault_inject_code[$past(txGroupIndex)], remote_alarm_send[$past(txGroupIndex)],
      spare_bit_value[$past(txGroupIndex)]} == $past(regWdata[3:0])) else $error("tx command wrong");
   loop_code_a: assert property (wrAt(OFS_DS2_TX_LOOPBACK_INSERT)
      |=> loopback_code[$past(txGroupIndex)] == $past(regWdata[3:0])) else $error("loop code wrong");
   ack_pulse_a: assert property (regAck == $past(regSel))
      else $error("ack not one cycle after request");
   idle_data_a: assert property ((!regSel || regWr) |=> regRdata == 16'h0000)
      else $error("read data not zero outside a read");
endmodule

// *** dv/mmr_line_model.sv ***
`timescale 1ns/1ps
module mmr_line_model #(
   parameter int MF_LEN = 40
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic arst_n,
   // Control from the bench.
   input wire logic run,
   input wire logic flood,
   // DS3 framer events.
   output logic multiframeEnd,
   output logic [8:0] spare_link_bits,
   output logic [5:0] evt
);
   int pos;
   always @(negedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pos <= 0;
         multiframeEnd <= 1'b0;
         evt <= 6'h00;
         spare_link_bits <= 9'h000;
      end else begin
         pos <= run ? (pos + 1) % MF_LEN : 0;
         multiframeEnd <= run && pos == MF_LEN - 1;
         evt <= ((run && (pos == 3 || pos == 5)) ? 6'h3f : 6'h00) | {5'h00, run && flood};
         spare_link_bits <= (run && pos == MF_LEN - 1) ? 9'($urandom) : ~spare_link_bits;
      end
   end
endmodule

// *** dv/mmr_monitor_regs_test.sv ***
`timescale 1ns/1ps
module mmr_monitor_regs_test;
   import mmr_pkg::*;
   localparam int MF = 40;
   logic clk, arst_n, regSel, regWr, regAck, run, flood, rdPend;
   logic ds3Async, ds3OutOfFrame, multiframeEnd, oneSecondTick, spareIrqEnable, spareIrq;
   logic counter_mode_select, spare_buffer_full_flag, aisMultiframeValid;
   logic [9:0] regAddr;
   logic [15:0] regWdata, regRdata, expVal;
   logic [8:0] spare_link_bits, spareSeen;
   logic [5:0] evt, alarm_frame_threshold;
   logic [3:0] aisErrCount;
   logic [2:0] txGroupIndex, rxGroupIndex;
   logic [NUM_GROUPS-1:0][1:0] loopbackCbitSel, fault_inject_code;
   logic [NUM_GROUPS-1:0] e1Mode, remote_alarm_send, spare_bit_value;
   logic [NUM_GROUPS-1:0][3:0] loopback_code;
   logic [15:0] cfgMem[NUM_GROUPS][3];
   logic [15:0] expQ[$];
   string nameQ[$];
   int errors, comparisons;
   mmr_monitor_regs mmr_monitor_regs_inst (
      .clk, .arst_n, .regSel, .regWr, .regAddr, .regWdata, .regRdata, .regAck,
      .ds3Async, .ds3OutOfFrame, .multiframeEnd, .spare_link_bits,
      .codeViolationEvt(evt[CI_CV]), .framingErrEvt(evt[CI_FB]), .pBitErrEvt(evt[CI_PB]),
      .pathParityErrEvt(evt[CI_CP]), .farEndBlockErrEvt(evt[CI_FE]), .zeroStringEvt(evt[CI_ZS]),
      .oneSecondTick, .spareIrqEnable, .counter_mode_select, .spare_buffer_full_flag, .spareIrq,
      .aisErrCount, .aisMultiframeValid, .alarm_frame_threshold, .txGroupIndex, .rxGroupIndex,
      .loopbackCbitSel, .e1Mode, .fault_inject_code, .remote_alarm_send, .spare_bit_value,
      .loopback_code);
   mmr_line_model #(.MF_LEN(MF)) mmr_line_model_inst (
      .clk, .arst_n, .run, .flood, .multiframeEnd, .spare_link_bits, .evt);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic check(input string n, input logic [16:0] e, input logic [16:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   always @(posedge clk) begin
      if (rdPend) begin
         check(nameQ.pop_front(), {1'b1, expQ.pop_front()}, {regAck, regRdata});
      end
      if (multiframeEnd === 1'b1) begin
         spareSeen = spare_link_bits;
      end
      rdPend = regSel === 1'b1 && regWr === 1'b0;
   end
   always @(negedge clk) aisErrCount <= 4'($urandom);
   task automatic access(input logic wr, input logic [9:0] a, input logic [15:0] d);
      {regSel, regWr, regAddr, regWdata} = {1'b1, wr, a, d};
      @(negedge clk);
   endtask
   task automatic rd(input string n, input logic [9:0] a, input logic [15:0] e);
      expQ.push_back(e);
      nameQ.push_back(n);
      access(1'b0, a, 16'h0000);
   endtask
   task automatic idle(input int n);
      regSel = 1'b0;
      repeat (n) @(negedge clk);
   endtask
   task automatic frames(input int k);
      regSel = 1'b0;
      run <= 1'b1;
      repeat (k * MF) @(negedge clk);
      run <= 1'b0;
      repeat (4) @(negedge clk);
   endtask
   task automatic tick();
      regSel = 1'b0;
      oneSecondTick = 1'b1;
      @(negedge clk);
      oneSecondTick = 1'b0;
      repeat (3) @(negedge clk);
   endtask
   task automatic counters(input int k, input logic a, input logic o);
      int m;
      for (int i = 0; i < NUM_COUNTERS; i++) begin
         m = (i == CI_PB || i == CI_CP || i == CI_FE) ? 1 : 2;
         m = ((i == CI_CV || i == CI_ZS) ? a : o) ? 0 : m;
         rd("counter", OFS_CODE_VIOLATION_COUNTER + 10'(4 * i), 16'(k * m));
      end
   endtask
   task automatic results();
      for (int i = 0; i < 50 && expQ.size() > 0; i++) @(negedge clk);
      if (expQ.size() > 0) errors++;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      errors++;
      results();
   end
   initial begin
      {arst_n, regSel, regWr, regAddr, regWdata, run, flood} = '0;
      {ds3Async, ds3OutOfFrame, oneSecondTick, spareIrqEnable, counter_mode_select} = '0;
      {errors, comparisons} = '0;
      void'($urandom(7));
      repeat (12) @(negedge clk);
      arst_n = 1'b1;
      rd("buffer", OFS_SPARE_LINK_RX_BUFFER, RST_SPARE_LINK_RX_BUFFER);
      for (int i = 0; i < 7; i++) rd("reset", OFS_CODE_VIOLATION_COUNTER + 10'(4 * i), RST_ZERO);
      for (int i = 0; i < 4; i++) rd("reset", OFS_DS2_TX_GROUP_SELECT + 10'(4 * i), RST_ZERO);
      rd("reset", OFS_DS2_RX_GROUP_SELECT, RST_ZERO);
      access(1'b1, 10'h1fc, 16'hffff);
      rd("unmapped", 10'h1fc, RST_ZERO);
      $display("test reset ended");
      for (int g = 0; g < NUM_GROUPS; g++) begin
         access(1'b1, OFS_DS2_TX_GROUP_SELECT, 16'(g));
         cfgMem[g][0] = {13'h0000, 2'($urandom % 3), 1'($urandom)};
         cfgMem[g][1] = 16'($urandom) & 16'h000f;
         cfgMem[g][2] = 16'($urandom) & 16'h000f;
         for (int r = 0; r < 3; r++) access(1'b1, OFS_DS2_TX_CONFIG + 10'(4 * r), cfgMem[g][r]);
      end
      for (int g = NUM_GROUPS - 1; g >= 0; g--) begin
         access(1'b1, OFS_DS2_TX_GROUP_SELECT, 16'(g));
         for (int r = 0; r < 3; r++) rd("ds2 tx", OFS_DS2_TX_CONFIG + 10'(4 * r), cfgMem[g][r]);
      end
      access(1'b1, OFS_DS2_TX_GROUP_SELECT, 16'h0007);
      rd("tx group", OFS_DS2_TX_GROUP_SELECT, 16'h0000);
      expVal = 16'($urandom % 7);
      access(1'b1, OFS_DS2_RX_GROUP_SELECT, expVal);
      access(1'b1, OFS_DS2_RX_GROUP_SELECT, 16'h0007);
      rd("rx group", OFS_DS2_RX_GROUP_SELECT, expVal);
      for (int b = 0; b < 2; b++) begin
         expVal = (16'($urandom) & 16'h003f) | 16'(b << 7);
         access(1'b1, OFS_ALARM_PARAMETERS, expVal | 16'hff40);
         rd("alarm", OFS_ALARM_PARAMETERS, expVal);
         idle(20);
      end
      $display("test settings ended");
      spareIrqEnable = 1'b1;
      frames(2);
      rd("buffer", OFS_SPARE_LINK_RX_BUFFER, {7'h00, spareSeen});
      access(1'b1, OFS_SPARE_LINK_RX_BUFFER, 16'h0000);
      rd("buffer", OFS_SPARE_LINK_RX_BUFFER, {7'h00, spareSeen});
      spareIrqEnable = 1'b0;
      frames(1);
      $display("test spare link ended");
      counters(3, 1'b0, 1'b0);
      counters(0, 1'b0, 1'b0);
      ds3Async = 1'b1;
      frames(2);
      counters(2, 1'b1, 1'b0);
      ds3Async = 1'b0;
      ds3OutOfFrame = 1'b1;
      frames(2);
      counters(2, 1'b0, 1'b1);
      ds3OutOfFrame = 1'b0;
      flood <= 1'b1;
      frames(1640);
      flood <= 1'b0;
      rd("saturated", OFS_CODE_VIOLATION_COUNTER, CNT_MAX);
      rd("cleared", OFS_CODE_VIOLATION_COUNTER, RST_ZERO);
      $display("test counters ended");
      counter_mode_select = 1'b1;
      idle(2);
      tick();
      frames(2);
      tick();
      for (int r = 0; r < 2; r++) counters(2, 1'b0, 1'b0);
      tick();
      counters(0, 1'b0, 1'b0);
      idle(2);
      $display("test errored second ended");
      results();
   end
endmodule
bind mmr_monitor_regs mmr_monitor_regs_props mmr_monitor_regs_props_inst (
   .clk, .arst_n, .regSel, .regWr, .regAddr, .regWdata, .regRdata, .regAck, .multiframeEnd,
   .spareIrqEnable, .spareIrq, .spare_buffer_full_flag, .aisErrCount, .aisMultiframeValid,
   .alarm_frame_threshold, .txGroupIndex, .rxGroupIndex, .loopbackCbitSel, .e1Mode,
   .fault_inject_code, .remote_alarm_send, .spare_bit_value, .loopback_code);
